// [irq_dma_cfg.svh]
// Offsets, vector codes, reset values and field widths of the flag-clear and DMA trigger block
`ifndef IRQ_DMA_CFG_SVH
`define IRQ_DMA_CFG_SVH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define IDX_TRIG_VEC0 8'h80
`define IDX_TRIG_VEC1 8'h81
`define IDX_TRIG_VEC2 8'h82
`define IDX_TRIG_VEC3 8'h83
`define IDX_FLAG_CLEAR 8'h88
`define IDX_SW_TRIG 8'h89
`define IDX_BURST_SEL 8'h8A
`define IDX_IRQ_STATUS 8'h8E
`define IDX_IRQ_MASK 8'h8F

// ----------------------------------------------------------------
// Widths and counts
// ----------------------------------------------------------------
`define PADDR_W 12
`define VEC_W 6
`define NUM_VEC 64
`define NUM_CH 4

// ----------------------------------------------------------------
// Vector codes
// ----------------------------------------------------------------
`define VEC_NONE 6'h00
`define VEC_EXT_IRQ_ZERO 6'h0A
`define VEC_SERIAL_RX0 6'h18
`define VEC_SERIAL_RX1 6'h1A
`define VEC_DMA_DONE0 6'h30
`define VEC_DMA_DONE1 6'h31
`define VEC_DMA_DONE2 6'h32
`define VEC_DMA_DONE3 6'h33

// ----------------------------------------------------------------
// Reset values and fixed answers
// ----------------------------------------------------------------
`define TRIG_VEC_RESET 6'h00
`define SW_TRIG_RESET 4'h0
`define BURST_RESET 4'h0
`define IRQ_STATUS_RESET 4'h0
`define IRQ_MASK_RESET 4'h0
`define DEFAULT_VECTOR 16'h0008
`define VEC_ADDR_PAGE 16'hFFFF

`endif

// [irq_dma_pkg.sv]
// Types shared by the flag-clear and DMA trigger block
package irq_dma_pkg;

  // Per-channel sequencing states, one-hot
  typedef enum logic [2:0] {
    CH_IDLE = 3'b001,
    CH_SINGLE = 3'b010,
    CH_BURST = 3'b100
  } ch_state_t;

  typedef logic [5:0] vec_t;

endpackage : irq_dma_pkg

// [dma_chan_seq.sv]
// One DMA channel sequencer: start, single or burst request, source flag release
`timescale 1ns/1ps
module dma_chan_seq
  import irq_dma_pkg::*;
(
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic hw_trig,
  input wire logic sw_trig,
  input wire logic burst_en,
  input wire logic xfer_ack,
  input wire logic count_zero,
  output logic xfer_req,
  output logic sw_taken,
  output logic src_clear
);

  ch_state_t state_reg;
  ch_state_t state_next;
  logic hw_src_reg;
  logic hw_src_next;
  logic start;

  // ----------------------------------------------------------------
  // Start and state decode
  // ----------------------------------------------------------------
  // Hardware trigger has priority; a pending software request waits a turn
  assign start = (state_reg == CH_IDLE) && (hw_trig || sw_trig);
  assign sw_taken = (state_reg == CH_IDLE) && sw_trig && !hw_trig;
  assign xfer_req = (state_reg != CH_IDLE);
  // Single: flag goes when the request is taken; burst: when the run ends
  assign src_clear = hw_src_reg && (((state_reg == CH_SINGLE) && xfer_ack)
                     || ((state_reg == CH_BURST) && count_zero));

  // Next state
  always_comb
  begin
    state_next = state_reg;
    hw_src_next = hw_src_reg;
    case (state_reg)
      CH_IDLE:
      begin
        if (start)
        begin
          state_next = burst_en ? CH_BURST : CH_SINGLE;
          hw_src_next = hw_trig;
        end
      end
      CH_SINGLE:
      begin
        if (xfer_ack || count_zero)
          state_next = CH_IDLE;
      end
      CH_BURST:
      begin
        // Keeps requesting with no further trigger until the count runs out
        if (count_zero)
          state_next = CH_IDLE;
      end
      default:
        state_next = CH_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_reg <= CH_IDLE;
      hw_src_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      hw_src_reg <= hw_src_next;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_burst_hold;
    @(posedge ref_clk) disable iff (!arst_n)
    (state_reg == CH_BURST && !count_zero) |=> xfer_req;
  endproperty
  a_burst_hold: assert property (p_burst_hold)
    else $error("burst request dropped before count reached zero");

  property p_burst_end_clear;
    @(posedge ref_clk) disable iff (!arst_n)
    (state_reg == CH_BURST && hw_src_reg && count_zero) |-> src_clear ##1 !xfer_req;
  endproperty
  a_burst_end_clear: assert property (p_burst_end_clear)
    else $error("burst end did not release source flag");

  c_burst_run: cover property (@(posedge ref_clk) disable iff (!arst_n)
    (state_reg == CH_BURST) [*3] ##1 count_zero);

endmodule : dma_chan_seq

// [irq_dma_ctrl.sv]
// Pending-flag clearing, vector answer and DMA trigger routing for four channels
// Operation
// - Flag-clear write of a vector clears that flag
// - Writing 0AH clears external interrupt zero flag
// - Matching vector makes source a DMA trigger
// - Counter zero raises channel completion request
// - Completion clears channel trigger-vector register
// - Equal vectors: lower channel served first
// - Burst bit: one trigger repeats until zero
// - Burst register, bit n for channel n
// - Cleared before vector read gives default 0008H
// - Edge-to-level switch or level fall clear irq zero
// - Serial receive buffer read clears receive flag
// - DMA request taken clears source flag
// - Burst termination clears the source flag
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`include "irq_dma_cfg.svh"
module irq_dma_ctrl
  import irq_dma_pkg::*;
(
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`PADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic [`NUM_VEC-1:0] src_event,
  input wire logic ext_irq_zero_level_mode,
  input wire logic ext_irq_zero_pin,
  input wire logic [1:0] serial_rx_read,
  output logic cpu_irq_req,
  output logic [`VEC_W-1:0] cpu_irq_vector,
  input wire logic cpu_accept,
  input wire logic cpu_vector_read,
  output logic [15:0] cpu_vector_value,
  output logic [23:0] cpu_fetch_addr,
  output logic [`NUM_CH-1:0] dma_req,
  input wire logic [`NUM_CH-1:0] dma_ack,
  input wire logic [`NUM_CH-1:0] dma_count_zero,
  output logic [`NUM_CH-1:0] dma_complete_irq,
  output logic irq
);

  localparam vec_t DONE_VEC [`NUM_CH] = '{`VEC_DMA_DONE0, `VEC_DMA_DONE1,
                                         `VEC_DMA_DONE2, `VEC_DMA_DONE3};
  localparam vec_t RX_VEC [2] = '{`VEC_SERIAL_RX0, `VEC_SERIAL_RX1};
  localparam logic [7:0] TRIG_IDX [`NUM_CH] = '{`IDX_TRIG_VEC0, `IDX_TRIG_VEC1,
                                               `IDX_TRIG_VEC2, `IDX_TRIG_VEC3};

  logic [`NUM_VEC-1:0] flag_reg;
  logic [`NUM_VEC-1:0] flag_next;
  logic [`NUM_VEC-1:0] flag_set;
  logic [`NUM_VEC-1:0] flag_clr;
  logic [`NUM_VEC-1:0] routed;
  logic [`NUM_VEC-1:0] cpu_pending;
  vec_t trig_vec_reg [`NUM_CH];
  logic [3:0] sw_trig_reg;
  logic [3:0] burst_reg;
  logic [3:0] irq_status_reg;
  logic [3:0] irq_mask_reg;
  logic [31:0] prdata_reg;
  logic irq_req_reg;
  vec_t irq_vec_reg;
  vec_t acc_vec_reg;
  logic acc_valid_reg;
  logic [15:0] vec_value_reg;
  logic ext0_mode_d_reg;
  logic ext0_pin_d_reg;
  logic [`NUM_CH-1:0] hw_trig;
  logic [`NUM_CH-1:0] lower_same;
  logic [`NUM_CH-1:0] sw_taken;
  logic [`NUM_CH-1:0] src_clear;
  vec_t pick_vec;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  // Printed offsets are word indices; the two low address bits must be zero
  wire [7:0] reg_idx = paddr[9:2];
  wire addr_ok = (paddr[1:0] == 2'b00) && (paddr[11:10] == 2'b00);
  wire hit_trig0 = addr_ok && (reg_idx == `IDX_TRIG_VEC0);
  wire hit_trig1 = addr_ok && (reg_idx == `IDX_TRIG_VEC1);
  wire hit_trig2 = addr_ok && (reg_idx == `IDX_TRIG_VEC2);
  wire hit_trig3 = addr_ok && (reg_idx == `IDX_TRIG_VEC3);
  wire hit_clear = addr_ok && (reg_idx == `IDX_FLAG_CLEAR);
  wire hit_sw = addr_ok && (reg_idx == `IDX_SW_TRIG);
  wire hit_burst = addr_ok && (reg_idx == `IDX_BURST_SEL);
  wire hit_status = addr_ok && (reg_idx == `IDX_IRQ_STATUS);
  wire hit_mask = addr_ok && (reg_idx == `IDX_IRQ_MASK);
  wire [3:0] hit_trig = {hit_trig3, hit_trig2, hit_trig1, hit_trig0};
  wire addr_hit = (|hit_trig) || hit_clear || hit_sw || hit_burst || hit_status || hit_mask;
  wire setup = psel && !penable;
  wire access = psel && penable;
  wire wr_en = access && pwrite && addr_hit;
  // Bits above bit 5 of a vector write are dropped
  wire [`VEC_W-1:0] wr_vec = pwdata[`VEC_W-1:0];
  wire clr_wr_en = wr_en && hit_clear;

  // Read data, captured in the setup cycle; the flag-clear register reads zero
  wire [31:0] rd_data =
    hit_trig0 ? {26'h0, trig_vec_reg[0]} :
    hit_trig1 ? {26'h0, trig_vec_reg[1]} :
    hit_trig2 ? {26'h0, trig_vec_reg[2]} :
    hit_trig3 ? {26'h0, trig_vec_reg[3]} :
    hit_sw ? {28'h0, sw_trig_reg} :
    hit_burst ? {28'h0, burst_reg} :
    hit_status ? {28'h0, irq_status_reg} :
    hit_mask ? {28'h0, irq_mask_reg} : 32'h0000_0000;

  // No wait state: the answer comes in the first access cycle
  assign pready = access;
  assign pslverr = access && !addr_hit;
  assign prdata = prdata_reg;

  // ----------------------------------------------------------------
  // Special clearing events for external interrupt zero
  // ----------------------------------------------------------------
  // Edge-to-level switch, or a falling pin while in level mode
  wire ext0_clear = (ext_irq_zero_level_mode && !ext0_mode_d_reg)
                    || (ext_irq_zero_level_mode && ext0_pin_d_reg && !ext_irq_zero_pin);

  // ----------------------------------------------------------------
  // Routing of sources to channels
  // ----------------------------------------------------------------
  // Vector zero means no source; on a shared vector only the lowest channel owns it
  always_comb
  begin
    routed = '0;
    lower_same = '0;
    hw_trig = '0;
    for (int c = 0; c < `NUM_CH; c++)
    begin
      for (int m = 0; m < c; m++)
      begin
        if (trig_vec_reg[m] == trig_vec_reg[c])
          lower_same[c] = 1'b1;
      end
      if (trig_vec_reg[c] != `VEC_NONE)
      begin
        routed[trig_vec_reg[c]] = 1'b1;
        hw_trig[c] = flag_reg[trig_vec_reg[c]] && !lower_same[c];
      end
    end
  end

  // Routed sources never reach the CPU
  assign cpu_pending = flag_reg & ~routed;

  // Lowest pending vector wins
  always_comb
  begin
    pick_vec = `VEC_NONE;
    for (int v = `NUM_VEC - 1; v >= 0; v--)
    begin
      if (cpu_pending[v])
        pick_vec = v[`VEC_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Channel sequencers
  // ----------------------------------------------------------------
  for (genvar c = 0; c < `NUM_CH; c++)
  begin : g_ch
    dma_chan_seq u_seq (
      .ref_clk(ref_clk),
      .arst_n(arst_n),
      .hw_trig(hw_trig[c]),
      .sw_trig(sw_trig_reg[c]),
      .burst_en(burst_reg[c]),
      .xfer_ack(dma_ack[c]),
      .count_zero(dma_count_zero[c]),
      .xfer_req(dma_req[c]),
      .sw_taken(sw_taken[c]),
      .src_clear(src_clear[c])
    );
  end

  // ----------------------------------------------------------------
  // Pending flags
  // ----------------------------------------------------------------
  // A set in the same cycle as any clear wins, so no event is lost
  always_comb
  begin
    flag_set = src_event;
    flag_clr = '0;
    for (int c = 0; c < `NUM_CH; c++)
    begin
      if (dma_count_zero[c])
        flag_set[DONE_VEC[c]] = 1'b1;
      if (src_clear[c])
        flag_clr[trig_vec_reg[c]] = 1'b1;
    end
    if (clr_wr_en)
      flag_clr[wr_vec] = 1'b1;
    if (cpu_vector_read && acc_valid_reg)
      flag_clr[acc_vec_reg] = 1'b1;
    if (ext0_clear)
      flag_clr[`VEC_EXT_IRQ_ZERO] = 1'b1;
    for (int r = 0; r < 2; r++)
    begin
      if (serial_rx_read[r])
        flag_clr[RX_VEC[r]] = 1'b1;
    end
    flag_next = (flag_reg & ~flag_clr) | flag_set;
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      flag_reg <= '0;
    else
      flag_reg <= flag_next;
  end

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  // Trigger vectors: completion empties the register, a same-cycle write re-arms it
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      trig_vec_reg <= '{default: `TRIG_VEC_RESET};
    else
      for (int c = 0; c < `NUM_CH; c++)
      begin
        if (wr_en && hit_trig[c])
          trig_vec_reg[c] <= wr_vec;
        else if (dma_count_zero[c])
          trig_vec_reg[c] <= `TRIG_VEC_RESET;
      end
  end

  // Software requests are held until the channel takes them; a new write wins
  wire [3:0] sw_wr = (wr_en && hit_sw) ? pwdata[3:0] : 4'h0;
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      sw_trig_reg <= `SW_TRIG_RESET;
    else
      sw_trig_reg <= (sw_trig_reg & ~sw_taken) | sw_wr;
  end

  // Burst select, plus the block's own event status and mask
  wire [3:0] status_w1c = (wr_en && hit_status) ? pwdata[3:0] : 4'h0;
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      burst_reg <= `BURST_RESET;
      irq_mask_reg <= `IRQ_MASK_RESET;
      irq_status_reg <= `IRQ_STATUS_RESET;
    end
    else
    begin
      if (wr_en && hit_burst)
        burst_reg <= pwdata[3:0];
      if (wr_en && hit_mask)
        irq_mask_reg <= pwdata[3:0];
      irq_status_reg <= (irq_status_reg & ~status_w1c) | dma_count_zero;
    end
  end

  // Read capture in setup
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      prdata_reg <= 32'h0000_0000;
    else if (setup)
      prdata_reg <= pwrite ? 32'h0000_0000 : rd_data;
  end

  // ----------------------------------------------------------------
  // CPU request, acceptance and vector answer
  // ----------------------------------------------------------------
  // If the flag vanished after acceptance the default vector is returned
  wire [15:0] vec_answer = flag_reg[acc_vec_reg] ? {8'h00, acc_vec_reg, 2'b00}
                                                 : `DEFAULT_VECTOR;
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      irq_req_reg <= 1'b0;
      irq_vec_reg <= `VEC_NONE;
      acc_vec_reg <= `VEC_NONE;
      acc_valid_reg <= 1'b0;
      vec_value_reg <= `DEFAULT_VECTOR;
      ext0_mode_d_reg <= 1'b0;
      ext0_pin_d_reg <= 1'b0;
    end
    else
    begin
      irq_req_reg <= |cpu_pending;
      irq_vec_reg <= pick_vec;
      ext0_mode_d_reg <= ext_irq_zero_level_mode;
      ext0_pin_d_reg <= ext_irq_zero_pin;
      if (cpu_accept)
      begin
        acc_vec_reg <= irq_vec_reg;
        acc_valid_reg <= 1'b1;
      end
      else if (cpu_vector_read)
        acc_valid_reg <= 1'b0;
      if (cpu_vector_read)
        vec_value_reg <= acc_valid_reg ? vec_answer : `DEFAULT_VECTOR;
    end
  end

  assign cpu_irq_req = irq_req_reg;
  assign cpu_irq_vector = irq_vec_reg;
  assign cpu_vector_value = vec_value_reg;
  assign cpu_fetch_addr = {`VEC_ADDR_PAGE, vec_value_reg[7:0]};
  assign dma_complete_irq = dma_count_zero;
  assign irq = |(irq_status_reg & irq_mask_reg);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_flag_clear;
    @(posedge ref_clk) disable iff (!arst_n)
    (clr_wr_en && !flag_set[wr_vec]) |=> !flag_reg[$past(wr_vec)];
  endproperty
  a_flag_clear: assert property (p_flag_clear)
    else $error("flag-clear write left the flag set");

  property p_ext0_clear;
    @(posedge ref_clk) disable iff (!arst_n)
    (clr_wr_en && wr_vec == `VEC_EXT_IRQ_ZERO && !src_event[`VEC_EXT_IRQ_ZERO])
      |=> !flag_reg[`VEC_EXT_IRQ_ZERO];
  endproperty
  a_ext0_clear: assert property (p_ext0_clear)
    else $error("code 0AH did not clear external interrupt zero");

  property p_route_start;
    @(posedge ref_clk) disable iff (!arst_n)
    (trig_vec_reg[0] != `VEC_NONE && flag_reg[trig_vec_reg[0]] && !dma_req[0])
      |=> dma_req[0];
  endproperty
  a_route_start: assert property (p_route_start)
    else $error("routed source did not start channel 0");

  property p_done_flag;
    @(posedge ref_clk) disable iff (!arst_n)
    dma_count_zero[1] |=> flag_reg[`VEC_DMA_DONE1] && irq_status_reg[1];
  endproperty
  a_done_flag: assert property (p_done_flag)
    else $error("completion request not raised");

  property p_vec_cleared;
    @(posedge ref_clk) disable iff (!arst_n)
    (dma_count_zero[2] && !(wr_en && hit_trig2)) |=> trig_vec_reg[2] == `VEC_NONE;
  endproperty
  a_vec_cleared: assert property (p_vec_cleared)
    else $error("trigger vector kept after completion");

  property p_chain_low_first;
    @(posedge ref_clk) disable iff (!arst_n)
    (trig_vec_reg[0] != `VEC_NONE && trig_vec_reg[0] == trig_vec_reg[1]
     && flag_reg[trig_vec_reg[0]] && dma_req[1:0] == 2'b00) |=> dma_req[1:0] == 2'b01;
  endproperty
  a_chain_low_first: assert property (p_chain_low_first)
    else $error("shared vector did not go to the lower channel");

  property p_burst_write;
    @(posedge ref_clk) disable iff (!arst_n)
    (wr_en && hit_burst) |=> burst_reg == $past(pwdata[3:0]);
  endproperty
  a_burst_write: assert property (p_burst_write)
    else $error("burst register did not take the write");

  property p_sw_start;
    @(posedge ref_clk) disable iff (!arst_n)
    (wr_en && hit_sw && pwdata[3]) |-> ##[1:3] dma_req[3];
  endproperty
  a_sw_start: assert property (p_sw_start)
    else $error("software request did not start channel 3");

  property p_default_vec;
    @(posedge ref_clk) disable iff (!arst_n)
    (cpu_vector_read && acc_valid_reg && !flag_reg[acc_vec_reg])
      |=> cpu_vector_value == `DEFAULT_VECTOR && cpu_fetch_addr[7:0] == 8'h08;
  endproperty
  a_default_vec: assert property (p_default_vec)
    else $error("default vector not given for a cleared flag");

  property p_ext0_event;
    @(posedge ref_clk) disable iff (!arst_n)
    (ext0_clear && !src_event[`VEC_EXT_IRQ_ZERO]) |=> !flag_reg[`VEC_EXT_IRQ_ZERO];
  endproperty
  a_ext0_event: assert property (p_ext0_event)
    else $error("pin or mode event did not clear interrupt zero");

  property p_rx_read;
    @(posedge ref_clk) disable iff (!arst_n)
    (serial_rx_read[0] && !src_event[`VEC_SERIAL_RX0]) |=> !flag_reg[`VEC_SERIAL_RX0];
  endproperty
  a_rx_read: assert property (p_rx_read)
    else $error("receive buffer read did not clear its flag");

  property p_take_clear;
    @(posedge ref_clk) disable iff (!arst_n)
    (src_clear[0] && !flag_set[trig_vec_reg[0]]) |=> !flag_reg[$past(trig_vec_reg[0])];
  endproperty
  a_take_clear: assert property (p_take_clear)
    else $error("taken DMA request left the source flag set");

  c_chain: cover property (@(posedge ref_clk) disable iff (!arst_n)
    dma_req[0] ##[1:20] dma_req[1]);
  c_default_vec: cover property (@(posedge ref_clk) disable iff (!arst_n)
    cpu_accept ##[1:5] (cpu_vector_read && !flag_reg[acc_vec_reg]));
  c_irq: cover property (@(posedge ref_clk) disable iff (!arst_n) $rose(irq));

endmodule : irq_dma_ctrl

// [dma_engine_model.sv]
// DMA engine stand-in: acknowledges requests and reports counter exhaustion
`timescale 1ns/1ps
module dma_engine_model
#(
  parameter int COUNT = 2
)
(
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic slow,
  input wire logic [3:0] dma_req,
  output logic [3:0] dma_ack,
  output logic [3:0] dma_count_zero
);
  int cnt [4];
  int gap [4];

  // One transfer per ack; slow mode idles three cycles before each one
  always @(posedge ref_clk or negedge arst_n)
  begin
    for (int c = 0; c < 4; c++)
    begin
      if (!arst_n)
      begin
        cnt[c] <= COUNT;
        gap[c] <= 0;
        dma_ack[c] <= 1'b0;
        dma_count_zero[c] <= 1'b0;
      end
      else if (dma_req[c] && !dma_ack[c] && gap[c] == 0)
      begin
        dma_ack[c] <= 1'b1;
        dma_count_zero[c] <= (cnt[c] == 1);
        cnt[c] <= (cnt[c] == 1) ? COUNT : cnt[c] - 1;
        gap[c] <= slow ? 3 : 0;
      end
      else
      begin
        dma_ack[c] <= 1'b0;
        dma_count_zero[c] <= 1'b0;
        gap[c] <= !dma_req[c] ? (slow ? 3 : 0) : (gap[c] > 0 ? gap[c] - 1 : 0);
      end
    end
  end
endmodule : dma_engine_model

// [irq_flag_clear_and_dma_trigger_bench.sv]
// Self-checking bench for the flag-clear and DMA trigger block
`timescale 1ns/1ps
`include "irq_dma_cfg.svh"
module irq_flag_clear_and_dma_trigger_bench
  import irq_dma_pkg::*;
;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic ext_irq_zero_level_mode = 1'b0;
  logic ext_irq_zero_pin = 1'b0;
  logic cpu_accept = 1'b0;
  logic cpu_vector_read = 1'b0;
  logic slow = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [63:0] src_event = 64'h0;
  logic [1:0] serial_rx_read = 2'h0;
  logic pready, pslverr, cpu_irq_req, irq, err;
  logic [31:0] prdata, rd;
  logic [5:0] cpu_irq_vector, v, w;
  logic [15:0] cpu_vector_value;
  logic [23:0] cpu_fetch_addr;
  logic [3:0] dma_req, dma_ack, dma_count_zero, dma_complete_irq;
  logic [7:0] regs [9] = '{8'h80, 8'h81, 8'h82, 8'h83, 8'h88, 8'h89, 8'h8A, 8'h8E, 8'h8F};
  int failures = 0;
  int compares = 0;
  int n;
  integer seed = 32'h4FAC1009;

  always #25 ref_clk = ~ref_clk;

  irq_dma_ctrl i_dut (.ref_clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .prdata, .pslverr, .src_event, .ext_irq_zero_level_mode, .ext_irq_zero_pin,
    .serial_rx_read, .cpu_irq_req, .cpu_irq_vector, .cpu_accept, .cpu_vector_read,
    .cpu_vector_value, .cpu_fetch_addr, .dma_req, .dma_ack, .dma_count_zero,
    .dma_complete_irq, .irq);

  dma_engine_model #(.COUNT(2)) i_engine (.ref_clk, .arst_n, .slow, .dma_req, .dma_ack,
    .dma_count_zero);

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string s, input logic [47:0] seen, input logic [47:0] exp);
    compares++;
    if (seen !== exp)
    begin
      failures++;
      $display("[ERR] %s expected %h seen %h", s, exp, seen);
    end
  endtask : chk

  task automatic conclude();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : conclude

  task automatic hang();
    chk("wait", 0, 1);
    conclude();
  endtask : hang

  // APB transfer held until pready is seen high at an edge
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++)
    begin
      @(posedge ref_clk);
      if (pready === 1'b1)
        break;
    end
    if (n == 20)
      hang();
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rchk(input string s, input logic [7:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0);
    chk(s, rd, exp);
  endtask : rchk

  task automatic tick(input int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask : tick

  task automatic ev(input logic [5:0] x);
    @(posedge ref_clk);
    src_event <= 64'h1 << x;
    @(posedge ref_clk);
    src_event <= 64'h0;
  endtask : ev

  // Bounded wait on a channel request (sel 0) or a completion pulse (sel 1)
  task automatic wait_on(input int sel, input int ch);
    for (n = 0; n < 80; n++)
    begin
      tick(1);
      if ((sel ? dma_complete_irq[ch] : dma_req[ch]) === 1'b1)
        return;
    end
    hang();
  endtask : wait_on

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (12) @(posedge ref_clk);
    arst_n <= 1'b1;
    for (int i = 0; i < 9; i++)
      rchk("reset", regs[i], 32'h0);
    apb(1'b0, 8'h90, 32'h0);
    chk("unmapped", err, 1);
    apb(1'b1, `IDX_TRIG_VEC1, 32'hFF);
    rchk("vec_bits", `IDX_TRIG_VEC1, 32'h3F);
    apb(1'b1, `IDX_TRIG_VEC1, 32'h0);
    ev(`VEC_EXT_IRQ_ZERO);
    tick(3);
    chk("int_zero", {cpu_irq_req, cpu_irq_vector}, {1'b1, `VEC_EXT_IRQ_ZERO});
    apb(1'b1, `IDX_FLAG_CLEAR, 32'hCA);
    tick(3);
    chk("clear_zero", cpu_irq_req, 0);
    $display("registers and clear done");
    // Odd passes clear the flag between accept and vector read
    for (int k = 0; k < 6; k++)
    begin
      v = 6'h01 + 6'($unsigned($random(seed)) % 40);
      ev(v);
      tick(3);
      chk("pending", {cpu_irq_req, cpu_irq_vector}, {1'b1, v});
      // The CPU stand-in never restores its mask level, so needs no guard
      @(posedge ref_clk);
      cpu_accept <= 1'b1;
      @(posedge ref_clk);
      cpu_accept <= 1'b0;
      if (k % 2)
        apb(1'b1, `IDX_FLAG_CLEAR, {26'h0, v});
      @(posedge ref_clk);
      cpu_vector_read <= 1'b1;
      @(posedge ref_clk);
      cpu_vector_read <= 1'b0;
      tick(2);
      chk("vector", {cpu_fetch_addr, cpu_vector_value}, (k % 2) ? 40'hFFFF080008 :
        {16'hFFFF, v, 2'b00, 8'h00, v, 2'b00});
      chk("gone", cpu_irq_req, 0);
    end
    $display("vector read done");
    ev(`VEC_EXT_IRQ_ZERO);
    ext_irq_zero_level_mode <= 1'b1;
    tick(3);
    chk("mode_clr", cpu_irq_req, 0);
    @(posedge ref_clk);
    ext_irq_zero_pin <= 1'b1;
    ev(`VEC_EXT_IRQ_ZERO);
    tick(3);
    chk("lvl_set", cpu_irq_req, 1);
    @(posedge ref_clk);
    ext_irq_zero_pin <= 1'b0;
    tick(3);
    chk("pin_fall", cpu_irq_req, 0);
    for (int i = 0; i < 2; i++)
    begin
      ev(i ? `VEC_SERIAL_RX1 : `VEC_SERIAL_RX0);
      serial_rx_read <= 2'h1 << i;
      @(posedge ref_clk);
      serial_rx_read <= 2'h0;
      tick(3);
      chk("rx_clr", cpu_irq_req, 0);
    end
    $display("special clears done");
    v = 6'h20 + 6'($unsigned($random(seed)) % 16);
    apb(1'b1, `IDX_TRIG_VEC0, {26'h0, v});
    for (int k = 0; k < 2; k++)
    begin
      ev(v);
      wait_on(0, 0);
      chk("routed", cpu_irq_req, 0);
      if (k)
        wait_on(1, 0);
      tick(4);
      chk("released", dma_req[0], 0);
    end
    rchk("vec_done", `IDX_TRIG_VEC0, 32'h0);
    rchk("status", `IDX_IRQ_STATUS, 32'h1);
    chk("masked", irq, 0);
    apb(1'b1, `IDX_IRQ_MASK, 32'h1);
    tick(0);
    chk("irq_on", irq, 1);
    apb(1'b1, `IDX_IRQ_STATUS, 32'h1);
    tick(0);
    chk("irq_off", irq, 0);
    ev(v);
    tick(3);
    chk("unrouted", {cpu_irq_req, cpu_irq_vector}, {1'b1, v});
    apb(1'b1, `IDX_FLAG_CLEAR, {26'h0, v});
    $display("single transfer done");
    // Two channels share one vector, engine answering slowly
    slow <= 1'b1;
    w = 6'h20 + 6'($unsigned($random(seed)) % 16);
    apb(1'b1, `IDX_TRIG_VEC0, {26'h0, w});
    apb(1'b1, `IDX_TRIG_VEC1, {26'h0, w});
    for (int k = 0; k < 4; k++)
    begin
      ev(w);
      wait_on(0, k / 2);
      chk("owner", dma_req, 4'h1 << (k / 2));
      if (k % 2)
        wait_on(1, k / 2);
      tick(8);
    end
    $display("chaining done");
    slow <= 1'b0;
    apb(1'b1, `IDX_BURST_SEL, 32'h8);
    rchk("burst", `IDX_BURST_SEL, 32'h8);
    apb(1'b1, `IDX_TRIG_VEC3, {26'h0, v});
    ev(v);
    wait_on(1, 3);
    for (int j = 0; j < 4; j++)
      apb(1'b1, `IDX_FLAG_CLEAR, {26'h0, `VEC_DMA_DONE0 + 6'(j)});
    tick(3);
    chk("burst_flag", cpu_irq_req, 0);
    $display("burst done");
    for (int k = 0; k < 2; k++)
    begin
      apb(1'b1, `IDX_SW_TRIG, 32'h9);
      wait_on(0, 0);
      if (k)
        wait_on(1, 0);
      tick(6);
    end
    rchk("sw_taken", `IDX_SW_TRIG, 32'h0);
    $display("software request done");
    conclude();
  end
endmodule : irq_flag_clear_and_dma_trigger_bench
